// File: bench/icac_bus_master.sv
`timescale 1ns/1ps
`default_nettype none

module icac_bus_master (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output var  logic o_scl_pull,
  output var  logic o_sda_pull,
  output var  logic o_stalled
);
  // Quarter of a 125 ns serial clock period
  localparam realtime QTR = 31.25;
  logic timed_out;
  initial begin
    timed_out  = 1'b0;
    o_scl_pull = 1'b0;
    o_sda_pull = 1'b0;
    o_stalled  = 1'b0;
  end
  // ---------
  // Release SCL; a slave may hold it low, so wait, but not forever
  // ---------
  task automatic scl_high;
    int n;
    n = 0;
    o_scl_pull = 1'b0;
    #1;
    while (i_scl !== 1'b1 && n < 4000) begin
      o_stalled = 1'b1;
      #5;
      n++;
    end
    if (n == 4000) timed_out = 1'b1;
    o_stalled = 1'b0;
  endtask
  task automatic put_bit(input logic v, output logic r);
    #QTR o_sda_pull = ~v;
    #QTR scl_high();
    #QTR r = i_sda;
    #QTR o_scl_pull = 1'b1;
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(b[i], r);
    put_bit(1'b1, ack);
  endtask
  task automatic start;
    o_sda_pull = 1'b1;
    #QTR o_scl_pull = 1'b1;
  endtask
  task automatic stop;
    #QTR o_sda_pull = 1'b1;
    #QTR scl_high();
    #QTR o_sda_pull = 1'b0;
    #QTR;
  endtask
endmodule // icac_bus_master

`default_nettype wire

// File: bench/icac_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "icac_map.vh"

module icac_chk (
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic [5:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0]  i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_scl,
  input wire logic        o_scl,
  input wire logic        o_scl_oe_n,
  input wire logic        i_sda,
  input wire logic        o_sda,
  input wire logic        o_sda_oe_n
);
  // ---------
  // Shadow of register writes and of the clock count on the wire
  // ---------
  logic [7:0] clk_q;
  logic       en_q;
  logic       scl_d;
  logic       sda_d;
  logic [3:0] rise_cnt;
  logic       acc;
  logic       wr_lo;
  logic       unmap;
  logic       req;
  assign req   = i_avs_read | i_avs_write;
  assign acc   = req & ~o_avs_waitrequest;
  assign wr_lo = acc & i_avs_write & i_avs_byteenable[0];
  assign unmap = i_avs_address[1:0] != 2'h0 || i_avs_address > 6'h14;
  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      clk_q    <= `ICAC_RST_CLK;
      en_q     <= 1'b0;
      rise_cnt <= 4'h0;
    end else begin
      if (wr_lo && i_avs_address == `ICAC_OFS_CLK)
        clk_q <= i_avs_writedata[7:0];
      if (wr_lo && i_avs_address == `ICAC_OFS_CTRL)
        en_q <= i_avs_writedata[`ICAC_CTRL_EN];
      // A START restarts the count; the ninth rise is the ack clock
      if (scl_d && i_scl && sda_d && !i_sda)
        rise_cnt <= 4'h0;
      else if (!scl_d && i_scl)
        rise_cnt <= (rise_cnt == 4'h9) ? 4'h1 : rise_cnt + 4'h1;
    end
    scl_d <= i_scl;
    sda_d <= i_sda;
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  clk_readback_a: assert property (
    acc && i_avs_read && i_avs_address == `ICAC_OFS_CLK
    |-> o_avs_readdata[7:0] == clk_q) else $error("clock readback wrong");
  clk_reset_a: assert property (
    wr_lo && i_avs_address == `ICAC_OFS_CLK
    && ((i_avs_writedata[7:0] ^ clk_q) & 8'hbf) != 8'h00
    |-> ##[1:4] o_scl_oe_n) else $error("clock write kept scl low");
  ack_ninth_a: assert property (
    clk_q[`ICAC_CLK_ACKCLK] && !o_sda_oe_n && i_scl && scl_d
    |-> rise_cnt == 4'h9) else $error("sda pulled off the ninth clock");
  nack_level_a: assert property (
    clk_q[`ICAC_CLK_ACKLVL] && rise_cnt == 4'h9 && i_scl && scl_d
    |-> o_sda_oe_n) else $error("ack given with level one");
  off_idle_a: assert property (
    !en_q |-> o_sda_oe_n && o_scl_oe_n) else $error("pull while disabled");
  drive_low_a: assert property (
    o_sda == 1'b0 && o_scl == 1'b0) else $error("open drain data not low");
  wait_first_a: assert property (
    $rose(req) |-> o_avs_waitrequest) else $error("no first wait cycle");
  one_wait_a: assert property (
    req && o_avs_waitrequest |=> !o_avs_waitrequest || !req)
    else $error("more than one wait cycle");
  unmapped_a: assert property (
    acc && i_avs_read && unmap |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");

  ack_seen_c: cover property (!o_sda_oe_n && i_scl && scl_d);
  clk_write_c: cover property (wr_lo && i_avs_address == `ICAC_OFS_CLK);
  stretch_c: cover property (!o_scl_oe_n);
endmodule // icac_chk

bind icac_ctrl icac_chk u_chk (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .i_scl(i_scl), .o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n));

`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "icac_map.vh"

module tb;
  typedef struct packed {
    logic [5:0] adr;
    logic [7:0] wd;
    logic [3:0] be;
    logic [7:0] exp;
  } icac_row_t;
  localparam icac_row_t ROWS [5] = '{
    '{`ICAC_OFS_CLK, 8'h85, 4'h1, 8'h85}, '{`ICAC_OFS_CLK, 8'h2a, 4'h0, 8'h85},
    '{6'h2c, 8'h5a, 4'h1, 8'h00}, '{`ICAC_OFS_CLK, 8'h3f, 4'h1, 8'h3f},
    '{`ICAC_OFS_CTRL, 8'h07, 4'h1, 8'h00}};
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  wire  [31:0] avs_readdata;
  wire         avs_wait;
  wire         d_scl, d_scl_oe_n, d_sda, d_sda_oe_n;
  wire         m_scl_pull, m_sda_pull, m_stalled;
  wire         scl_line, sda_line;
  int          num_errors = 0;
  int          n_compared = 0;
  logic [7:0]  q;
  logic        ack;
  // Open-drain wires with pull-ups
  assign scl_line = ~m_scl_pull & (d_scl_oe_n | d_scl);
  assign sda_line = ~m_sda_pull & (d_sda_oe_n | d_sda);
  always #2.5 sys_clk = ~sys_clk;

  icac_ctrl dut (
    .i_sys_clk(sys_clk), .i_rst(rst), .i_avs_address(avs_address),
    .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .i_avs_byteenable(avs_byteenable),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_wait),
    .i_scl(scl_line), .o_scl(d_scl), .o_scl_oe_n(d_scl_oe_n),
    .i_sda(sda_line), .o_sda(d_sda), .o_sda_oe_n(d_sda_oe_n));
  icac_bus_master pm (.i_scl(scl_line), .i_sda(sda_line),
    .o_scl_pull(m_scl_pull), .o_sda_pull(m_sda_pull), .o_stalled(m_stalled));

  // ---------
  // Checks, verdict and register bus master
  // ---------
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low; data taken at that edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_read <= ~w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    @(negedge sys_clk);
    while (avs_wait !== 1'b0 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 40) begin
      num_errors++;
      $display("[ERR] %0t bus hang", $time);
      report_and_stop();
    end
    @(posedge sys_clk);
    r = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, a, d, 4'h1, x);
  endtask
  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 8'h00, 4'h1, q);
  endtask
  task automatic addr_try(input logic [7:0] cfg, input logic [7:0] a);
    wr(`ICAC_OFS_CLK, cfg);
    pm.start();
    pm.put_byte(a, ack);
    chk_bit(ack, 1'b1);
    pm.stop();
  endtask

  initial begin
    int n;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`ICAC_OFS_CLK);
    chk_byte(q, `ICAC_RST_CLK);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, ROWS[i].adr, ROWS[i].wd, ROWS[i].be, q);
      rd(ROWS[i].adr);
      chk_byte(q, ROWS[i].exp);
    end
    $display("test register rows done");
    wr(`ICAC_OFS_CTRL2, 8'h20);
    rd(`ICAC_OFS_CTRL2);
    chk_byte(q, 8'h00);
    wr(`ICAC_OFS_OWNADR, 8'ha4);
    wr(`ICAC_OFS_CTRL, 8'h08);
    wr(`ICAC_OFS_CLK, 8'h80);
    pm.start();
    rd(`ICAC_OFS_CTRL);
    chk_byte(q & 8'h07, 8'h00);
    pm.put_byte(8'ha4, ack);
    chk_bit(ack, 1'b0);
    pm.put_byte(8'h3c, ack);
    chk_bit(ack, 1'b0);
    pm.stop();
    rd(`ICAC_OFS_DATA);
    chk_byte(q, 8'h3c);
    $display("test slave receive done");
    addr_try(8'hc0, 8'ha4);
    addr_try(8'h80, 8'hb6);
    $display("test no ack done");
    pm.start();
    repeat (3) pm.put_bit(1'b1, ack);
    // Let the last fall pass the pin synchroniser first
    repeat (4) @(posedge sys_clk);
    rd(`ICAC_OFS_CTRL);
    chk_byte(q & 8'h07, 8'h03);
    wr(`ICAC_OFS_DATA, 8'h00);
    rd(`ICAC_OFS_CTRL);
    chk_byte(q & 8'h07, 8'h00);
    pm.stop();
    $display("test counter reset done");
    pm.start();
    pm.put_byte(8'ha4, ack);
    pm.put_byte(8'h11, ack);
    pm.put_byte(8'h22, ack);
    fork
      pm.put_byte(8'h33, ack);
      begin
        n = 0;
        while (m_stalled !== 1'b1 && n < 400) begin
          @(posedge sys_clk);
          n++;
        end
        chk_bit(n < 400, 1'b1);
        rd(`ICAC_OFS_CTRL2);
        chk_bit(q[`ICAC_CTRL2_WAIT], 1'b1);
        rd(`ICAC_OFS_DATA);
        chk_byte(q, 8'h11);
        rd(`ICAC_OFS_DATA);
        chk_byte(q, 8'h22);
      end
    join
    chk_bit(ack, 1'b0);
    pm.stop();
    rd(`ICAC_OFS_DATA);
    chk_byte(q, 8'h33);
    $display("test buffer stall done");
    chk_bit(pm.timed_out, 1'b0);
    report_and_stop();
  end
endmodule // tb

`default_nettype wire

// File: logic/icac_buf2.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Two-entry buffer, head entry is the registered output
// ----------------------------------------------------------------
module icac_buf2 #(
  parameter WIDTH = 8
) (
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire             i_in_valid,
  input  wire [WIDTH-1:0] i_in_data,
  output wire             o_in_ready,
  output wire             o_out_valid,
  output reg  [WIDTH-1:0] o_out_data,
  input  wire             i_out_ready
);

  reg [WIDTH-1:0] tail;
  reg [1:0]       cnt;
  wire            push;
  wire            pop;

  assign o_in_ready  = (cnt != 2'h2);
  assign o_out_valid = (cnt != 2'h0);
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt        <= 2'h0;
      o_out_data <= {WIDTH{1'b0}};
      tail       <= {WIDTH{1'b0}};
    end else begin
      if (push && (cnt == 2'h0 || (cnt == 2'h1 && pop))) begin
        o_out_data <= i_in_data;
      end else if (pop && cnt == 2'h2) begin
        o_out_data <= tail;
      end
      if (push && ((cnt == 2'h1 && !pop) || (cnt == 2'h2 && pop))) begin
        tail <= i_in_data;
      end
      if (push && !pop) begin
        cnt <= cnt + 2'h1;
      end else if (pop && !push) begin
        cnt <= cnt - 2'h1;
      end
    end
  end

endmodule // icac_buf2

`default_nettype wire

// File: logic/icac_ctrl.v
// Behaviour
// - Frequency code sets serial clock rate
// - Bit 5 picks standard or fast mode
// - Ack level bit drives data low or high
// - Address match auto-acks when level is 0
// - Ack clock enable adds clock after byte
// - Sender releases data line during ack
// - Clock control change other than ack level mid-transfer resets clock
// - Data write mid-transfer resets bit counter
// - Bit counter clears at start and byte end
// - Wait bit reads internal wait flag
// - Hardware updates status bits continuously
`timescale 1ns/1ps
`default_nettype none
`include "icac_map.vh"

module icac_ctrl (
  input  wire        i_sys_clk,
  input  wire        i_rst,
  input  wire [5:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  input  wire        i_scl,
  output wire        o_scl,
  output wire        o_scl_oe_n,
  input  wire        i_sda,
  output wire        o_sda,
  output wire        o_sda_oe_n
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam [1:0] M_IDLE  = 2'h0;
  localparam [1:0] M_START = 2'h1;
  localparam [1:0] M_RUN   = 2'h2;
  localparam [1:0] M_STOP  = 2'h3;

  localparam [2:0] S_DATA  = 3'h0;
  localparam [2:0] S_OWN   = 3'h1;
  localparam [2:0] S_CTRL  = 3'h2;
  localparam [2:0] S_CLK   = 3'h3;
  localparam [2:0] S_STAT  = 3'h4;
  localparam [2:0] S_CTRL2 = 3'h5;
  localparam [2:0] S_NONE  = 3'h7;

  reg        bus_ack;
  reg [6:0]  own_adr;
  reg        ctrl_en;
  reg [7:0]  clk_ctrl;
  reg [4:0]  clk_div;
  reg        master_select;
  reg        transmit_direction_select;
  reg        busy;
  reg        addressed;
  reg        rx_ack;
  reg [2:0]  bit_cnt;
  reg        ack_phase;
  reg        ack_addr;
  reg        first_byte;
  reg        skip_fall;
  reg [7:0]  shift;
  reg        rx_bit;
  reg [7:0]  rx_hold;
  reg        rx_pend;
  reg        tx_need;
  reg        go;
  reg [1:0]  mstate;
  reg        m_scl_low;
  reg        m_sda_low;
  reg        m_sda_own;
  reg [4:0]  div_cnt;
  reg [5:0]  half_cnt;
  reg        scl_q;
  reg        sda_q;
  reg [2:0]  rd_sel;
  reg [31:0] rd_mux;

  wire       scl_s;
  wire       sda_s;
  wire       tick;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;
  wire       byte_end;
  wire       ack_end;
  wire [7:0] next_shift;
  wire       rd_go;
  wire       wr_go;
  wire [2:0] wr_sel;
  wire [7:0] wd;
  wire       clk_rst;
  wire [5:0] half_len;
  wire       half_done;
  wire       hold_scl;
  wire       eng_sda_low;
  wire       ack_drive;
  wire       rx_in_ready;
  wire       rx_out_valid;
  wire [7:0] rx_out_data;
  wire       rx_pop;
  wire       receiving;

  // ----------------------------------------------------------------
  // Address decode, shared by read and write paths
  // ----------------------------------------------------------------
  function [2:0] reg_sel;
    input [5:0] adr;
    begin
      case (adr)
        `ICAC_OFS_DATA:   reg_sel = S_DATA;
        `ICAC_OFS_OWNADR: reg_sel = S_OWN;
        `ICAC_OFS_CTRL:   reg_sel = S_CTRL;
        `ICAC_OFS_CLK:    reg_sel = S_CLK;
        `ICAC_OFS_STAT:   reg_sel = S_STAT;
        `ICAC_OFS_CTRL2:  reg_sel = S_CTRL2;
        default:          reg_sel = S_NONE;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and line events
  // ----------------------------------------------------------------
  icac_sync #(
    .WIDTH (2)
  ) u_sync (
    .i_clk (i_sys_clk),
    .i_rst (i_rst),
    .i_d   ({i_scl, i_sda}),
    .o_q   ({scl_s, sda_s})
  );

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise  = ctrl_en & scl_s & ~scl_q;
  assign scl_fall  = ctrl_en & ~scl_s & scl_q;
  assign start_det = ctrl_en & scl_s & scl_q & sda_q & ~sda_s;
  assign stop_det  = ctrl_en & scl_s & scl_q & ~sda_q & sda_s;

  // ----------------------------------------------------------------
  // Avalon-MM slave, one wait cycle per access
  // ----------------------------------------------------------------
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~bus_ack;
  assign rd_go  = i_avs_read & bus_ack;
  assign wr_go  = i_avs_write & bus_ack & i_avs_byteenable[0];
  assign wr_sel = reg_sel(i_avs_address);
  assign wd     = i_avs_writedata[7:0];

  always @* begin
    rd_sel = reg_sel(i_avs_address);
    rd_mux = 32'h0000_0000;
    case (rd_sel)
      S_DATA:  rd_mux[7:0] = rx_out_valid ? rx_out_data : shift;
      S_OWN:   rd_mux[7:0] = {own_adr, 1'b0};
      S_CTRL:  rd_mux[7:0] = {4'h0, ctrl_en, bit_cnt};
      S_CLK:   rd_mux[7:0] = clk_ctrl;
      S_STAT:  rd_mux[7:0] = {master_select, transmit_direction_select, busy, addressed,
                              2'h0, rx_out_valid, rx_ack};
      S_CTRL2: rd_mux[7:0] = {2'h0, hold_scl, clk_div};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      bus_ack        <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      bus_ack <= (i_avs_read | i_avs_write) & ~bus_ack;
      if (i_avs_read & ~bus_ack) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Changing anything but the ack level while busy resets the clock sequencer to idle
  assign clk_rst = wr_go & (wr_sel == S_CLK) & busy &
                   ({wd[7], wd[5:0]} != {clk_ctrl[7], clk_ctrl[5:0]});

  always @(posedge i_sys_clk) begin
    if (i_rst) begin
      own_adr  <= `ICAC_RST_OWNADR;
      ctrl_en  <= 1'b0;
      clk_ctrl <= `ICAC_RST_CLK;
      clk_div  <= `ICAC_RST_DIV;
    end else if (wr_go) begin
      case (wr_sel)
        S_OWN:   own_adr  <= wd[7:1];
        S_CTRL:  ctrl_en  <= wd[`ICAC_CTRL_EN];
        S_CLK:   clk_ctrl <= wd;
        // Divider is meant to change only while disabled
        S_CTRL2: clk_div  <= wd[4:0];
        default: ctrl_en  <= ctrl_en;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Serial clock timing
  // ----------------------------------------------------------------
  // Fast mode halves the high and low phase length
  assign half_len = clk_ctrl[`ICAC_CLK_FAST] ?
                    {1'b0, clk_ctrl[`ICAC_CLK_CODE_MSB:0]} :
                    {clk_ctrl[`ICAC_CLK_CODE_MSB:0], 1'b0};
  assign half_done = tick & (half_cnt + 6'h01 >= half_len) &
                     (half_cnt + 6'h01 >= `ICAC_MIN_HALF);
  assign tick = ctrl_en & (div_cnt == clk_div);

  always @(posedge i_sys_clk) begin
    if (i_rst || !ctrl_en || tick) begin
      div_cnt <= 5'h00;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // Master start, clocking and stop sequencer
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (i_rst || !ctrl_en || clk_rst) begin
      mstate    <= M_IDLE;
      m_scl_low <= 1'b0;
      m_sda_low <= 1'b0;
      m_sda_own <= 1'b0;
      half_cnt  <= 6'h00;
    end else begin
      if (half_done) begin
        half_cnt <= 6'h00;
      end else if (tick) begin
        half_cnt <= half_cnt + 6'h01;
      end
      case (mstate)
        M_IDLE: begin
          half_cnt <= 6'h00;
          if (wr_go && wr_sel == S_STAT && wd[`ICAC_STAT_MST] &&
              wd[`ICAC_STAT_BUSY] && !busy) begin
            mstate    <= M_START;
            m_sda_own <= 1'b1;
          end
        end
        M_START: begin
          if (half_done && !m_sda_low) begin
            m_sda_low <= 1'b1;
          end else if (half_done) begin
            m_scl_low <= 1'b1;
            m_sda_own <= 1'b0;
            mstate    <= M_RUN;
          end
        end
        M_RUN: begin
          if (wr_go && wr_sel == S_STAT && !wd[`ICAC_STAT_BUSY] &&
              m_scl_low && !go) begin
            mstate    <= M_STOP;
            m_sda_own <= 1'b1;
            m_sda_low <= 1'b1;
            half_cnt  <= 6'h00;
          end else if (!m_scl_low && !scl_s) begin
            // Another party stretches the clock, clear the count
            half_cnt <= 6'h00;
          end else if (half_done && m_scl_low && go && !hold_scl) begin
            m_scl_low <= 1'b0;
          end else if (half_done && !m_scl_low) begin
            m_scl_low <= 1'b1;
          end
        end
        M_STOP: begin
          if (half_done && m_scl_low) begin
            m_scl_low <= 1'b0;
          end else if (half_done) begin
            m_sda_low <= 1'b0;
            m_sda_own <= 1'b0;
            mstate    <= M_IDLE;
          end
        end
        default: mstate <= M_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Bit engine
  // ----------------------------------------------------------------
  assign next_shift = {shift[6:0], rx_bit};
  assign byte_end   = scl_fall & ~ack_phase & ~skip_fall &
                      (bit_cnt == 3'h7);
  assign ack_end    = scl_fall & ack_phase;
  assign receiving  = ~transmit_direction_select & (master_select | addressed) & ~first_byte;
  assign rx_pop     = rd_go & (wr_sel == S_DATA);

  always @(posedge i_sys_clk) begin
    if (i_rst || !ctrl_en) begin
      bit_cnt    <= 3'h0;
      ack_phase  <= 1'b0;
      ack_addr   <= 1'b0;
      skip_fall  <= 1'b0;
      first_byte <= 1'b0;
      shift      <= 8'h00;
      rx_bit     <= 1'b1;
      rx_ack     <= 1'b1;
      busy       <= 1'b0;
      addressed  <= 1'b0;
      master_select        <= 1'b0;
      transmit_direction_select        <= 1'b0;
      go         <= 1'b0;
      rx_hold    <= 8'h00;
      rx_pend    <= 1'b0;
      tx_need    <= 1'b0;
    end else begin
      if (rx_pend && rx_in_ready) begin
        rx_pend <= 1'b0;
      end
      if (wr_go && wr_sel == S_STAT) begin
        master_select <= wd[`ICAC_STAT_MST];
        transmit_direction_select <= wd[`ICAC_STAT_TRX];
        if (wd[`ICAC_STAT_MST] && wd[`ICAC_STAT_BUSY] && !busy) begin
          go <= 1'b1;
        end
      end
      if (rx_pop && master_select && busy && !transmit_direction_select) begin
        go <= 1'b1;
      end
      if (wr_go && wr_sel == S_DATA) begin
        shift   <= wd;
        bit_cnt <= 3'h0;
        tx_need <= 1'b0;
        go      <= master_select & busy;
      end
      if (scl_rise && !ack_phase) begin
        rx_bit <= sda_s;
      end
      if (scl_rise && ack_phase) begin
        rx_ack <= sda_s;
      end
      // The fall that closes a START carries no data bit
      if (scl_fall) begin
        skip_fall <= 1'b0;
      end
      if (scl_fall && !ack_phase && !skip_fall) begin
        shift   <= next_shift;
        bit_cnt <= bit_cnt + 3'h1;
      end
      if (byte_end) begin
        bit_cnt    <= 3'h0;
        ack_phase  <= clk_ctrl[`ICAC_CLK_ACKCLK];
        ack_addr   <= first_byte;
        first_byte <= 1'b0;
        go         <= go & clk_ctrl[`ICAC_CLK_ACKCLK];
        if (first_byte && !master_select) begin
          addressed <= (next_shift[7:1] == own_adr);
          if (next_shift[7:1] == own_adr) begin
            transmit_direction_select <= next_shift[0];
          end
        end
        if (receiving) begin
          rx_hold <= next_shift;
          rx_pend <= 1'b1;
        end
        if (!clk_ctrl[`ICAC_CLK_ACKCLK] && transmit_direction_select && addressed && !master_select) begin
          tx_need <= 1'b1;
        end
      end
      if (ack_end) begin
        ack_phase <= 1'b0;
        go        <= 1'b0;
        if (transmit_direction_select && !master_select && (addressed || ack_addr)) begin
          tx_need <= 1'b1;
        end
      end
      if (start_det) begin
        bit_cnt    <= 3'h0;
        ack_phase  <= 1'b0;
        first_byte <= 1'b1;
        skip_fall  <= 1'b1;
        busy       <= 1'b1;
        addressed  <= 1'b0;
      end
      if (stop_det) begin
        busy      <= 1'b0;
        master_select       <= 1'b0;
        addressed <= 1'b0;
        go        <= 1'b0;
        tx_need   <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer, a full buffer stretches the clock
  // ----------------------------------------------------------------
  icac_buf2 #(
    .WIDTH (8)
  ) u_rxbuf (
    .i_clk       (i_sys_clk),
    .i_rst       (i_rst),
    .i_in_valid  (rx_pend),
    .i_in_data   (rx_hold),
    .o_in_ready  (rx_in_ready),
    .o_out_valid (rx_out_valid),
    .o_out_data  (rx_out_data),
    .i_out_ready (rx_pop)
  );

  // ----------------------------------------------------------------
  // Line drivers
  // ----------------------------------------------------------------
  // Wait: a byte not yet stored, or a slave with nothing to send
  assign hold_scl = busy & (rx_pend | tx_need);

  // Receiver answers, the sender leaves the line released
  assign ack_drive = ack_addr ?
                     (~master_select & addressed & ~clk_ctrl[`ICAC_CLK_ACKLVL]) :
                     (~transmit_direction_select & (master_select | addressed) &
                      ~clk_ctrl[`ICAC_CLK_ACKLVL]);

  assign eng_sda_low = ack_phase ? ack_drive :
                       (busy & transmit_direction_select & (master_select | addressed) & ~first_byte &
                        ~shift[7]) |
                       (busy & master_select & first_byte & ~shift[7]);

  // Open drain: the output is always low, the enable releases it
  assign o_scl      = 1'b0;
  assign o_sda      = 1'b0;
  assign o_scl_oe_n = ~(m_scl_low | (hold_scl & ~scl_s));
  assign o_sda_oe_n = ~(m_sda_own ? m_sda_low : eng_sda_low);

endmodule // icac_ctrl

`default_nettype wire

// File: logic/icac_map.vh
`ifndef ICAC_MAP_VH
`define ICAC_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ICAC_OFS_DATA    6'h00
`define ICAC_OFS_OWNADR  6'h04
`define ICAC_OFS_CTRL    6'h08
`define ICAC_OFS_CLK     6'h0c
`define ICAC_OFS_STAT    6'h10
`define ICAC_OFS_CTRL2   6'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ICAC_CLK_CODE_MSB  4
`define ICAC_CLK_FAST      5
`define ICAC_CLK_ACKLVL    6
`define ICAC_CLK_ACKCLK    7
`define ICAC_CTRL_EN       3
`define ICAC_STAT_MST      7
`define ICAC_STAT_TRX      6
`define ICAC_STAT_BUSY     5
`define ICAC_STAT_ADDR     4
`define ICAC_STAT_RXAV     1
`define ICAC_STAT_RXACK    0
`define ICAC_CTRL2_WAIT    5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ICAC_RST_CLK     8'h00
`define ICAC_RST_OWNADR  7'h00
`define ICAC_RST_DIV     5'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ICAC_MIN_HALF    6'h01

`endif

// File: logic/icac_sync.v
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------------------------------
module icac_sync #(
  parameter WIDTH = 2
) (
  input  wire             i_clk,
  input  wire             i_rst,
  input  wire [WIDTH-1:0] i_d,
  output reg  [WIDTH-1:0] o_q
);

  reg [WIDTH-1:0] meta;

  // Idle bus lines are high, so reset to ones
  always @(posedge i_clk) begin
    if (i_rst) begin
      meta <= {WIDTH{1'b1}};
      o_q  <= {WIDTH{1'b1}};
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end

endmodule // icac_sync

`default_nettype wire
